/* File: rtl/rbw_cfg.svh */
// Constants of the watchdog and analog control register bank.
// Assumes a 200 MHz core clock and 32-bit AXI4-Lite words.
`ifndef RBW_CFG_SVH
`define RBW_CFG_SVH
// Register indices, byte address is four times the index
`define RBW_IDX_WDG      6'h00
`define RBW_IDX_ACZ      6'h01
`define RBW_IDX_ACO      6'h02
`define RBW_IDX_STAT     6'h03
`define RBW_IDX_REV      6'h05
`define RBW_IDX_IRQS     6'h08
`define RBW_IDX_IRQM     6'h09
// Reset values and writable bit masks
`define RBW_WDG_RST      8'h0f
`define RBW_WDG_MASK     8'h8f
`define RBW_ACZ_RST      8'h74
`define RBW_ACZ_MASK     8'h7f
`define RBW_ACO_RST      8'h60
`define RBW_ACO_MASK     8'h7e
`define RBW_REV_DEFAULT  8'h11
// Field positions
`define RBW_WDG_EN_BIT   7
`define RBW_WDG_SEL_MSB  3
`define RBW_HV_EN_BIT    6
`define RBW_CONV_EN_BIT  5
`define RBW_CLK_EN_BIT   4
`define RBW_TRIG_EN_BIT  3
`define RBW_CLIM_MSB     2
`define RBW_IRQ_WDG_BIT  0
// Bus answers
`define RBW_RESP_OKAY    2'h0
`define RBW_RESP_SLVERR  2'h2
// Time base
`define RBW_CLK_PERIOD_NS 5
`define RBW_NS_PER_MS     1000000
`define RBW_MS_CYCLES     (`RBW_NS_PER_MS / `RBW_CLK_PERIOD_NS)
`define RBW_MS_CNT_W      18
// Watchdog periods in ms per timeout code
`define RBW_WDG_MS_0     10'h021
`define RBW_WDG_MS_1     10'h042
`define RBW_WDG_MS_2     10'h062
`define RBW_WDG_MS_3     10'h083
`define RBW_WDG_MS_4     10'h0a4
`define RBW_WDG_MS_5     10'h0c5
`define RBW_WDG_MS_6     10'h0e5
`define RBW_WDG_MS_7     10'h106
`define RBW_WDG_MS_8     10'h127
`define RBW_WDG_MS_9     10'h148
`define RBW_WDG_MS_10    10'h168
`define RBW_WDG_MS_11    10'h189
`define RBW_WDG_MS_12    10'h1aa
`define RBW_WDG_MS_13    10'h1cb
`define RBW_WDG_MS_14    10'h1ec
`define RBW_WDG_MS_15    10'h20c
`endif

/* File: rtl/rbw_pkg.sv */
// Types of the watchdog and analog control register bank.
// Assumes the constants of rbw_cfg.svh.
package rbw_pkg;
    typedef enum logic [1:0] {
        RBW_WDG_IDLE = 2'h1,
        RBW_WDG_RUN  = 2'h2
    } rbw_wdg_state_t;
    typedef logic [7:0] rbw_byte_t;
    typedef logic [9:0] rbw_ms_t;
endpackage

/* File: rtl/rbw_wdg_if.sv */
// Carrier between register bank and watchdog timer.
// Assumes both ends share clk and sys_rst.
`timescale 1ns/100ps
`default_nettype none
interface rbw_wdg_if;
    logic       restart;
    logic       enable;
    logic [3:0] timeoutSel;
    logic       expired;
    modport bank (output restart, output enable, output timeoutSel, input expired);
    modport timer (input restart, input enable, input timeoutSel, output expired);
endinterface
`default_nettype wire

/* File: rtl/rbw_watchdog.sv */
// Watchdog timer counted in milliseconds from the core clock.
// Assumes restart is a one-cycle pulse from the register bank.
`include "rbw_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module rbw_watchdog
    import rbw_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `RBW_MS_CYCLES
) (
    input  wire logic  clk,
    input  wire logic  sys_rst,
    input  wire logic  ce,
    rbw_wdg_if.timer   wd
);
    rbw_wdg_state_t             state;
    logic [`RBW_MS_CNT_W-1:0]   msCnt;
    rbw_ms_t                    elapsedMs;
    rbw_ms_t                    periodMs;
    logic                       msTick;

    function automatic rbw_ms_t wdgPeriodMs(input logic [3:0] sel);
        case (sel)
            4'h0: wdgPeriodMs = `RBW_WDG_MS_0;
            4'h1: wdgPeriodMs = `RBW_WDG_MS_1;
            4'h2: wdgPeriodMs = `RBW_WDG_MS_2;
            4'h3: wdgPeriodMs = `RBW_WDG_MS_3;
            4'h4: wdgPeriodMs = `RBW_WDG_MS_4;
            4'h5: wdgPeriodMs = `RBW_WDG_MS_5;
            4'h6: wdgPeriodMs = `RBW_WDG_MS_6;
            4'h7: wdgPeriodMs = `RBW_WDG_MS_7;
            4'h8: wdgPeriodMs = `RBW_WDG_MS_8;
            4'h9: wdgPeriodMs = `RBW_WDG_MS_9;
            4'ha: wdgPeriodMs = `RBW_WDG_MS_10;
            4'hb: wdgPeriodMs = `RBW_WDG_MS_11;
            4'hc: wdgPeriodMs = `RBW_WDG_MS_12;
            4'hd: wdgPeriodMs = `RBW_WDG_MS_13;
            4'he: wdgPeriodMs = `RBW_WDG_MS_14;
            default: wdgPeriodMs = `RBW_WDG_MS_15;
        endcase
    endfunction

    assign msTick = (msCnt == `RBW_MS_CNT_W'(MS_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state     <= RBW_WDG_IDLE;
            msCnt     <= '0;
            elapsedMs <= '0;
            periodMs  <= `RBW_WDG_MS_15;
            wd.expired <= 1'b0;
        end else if (ce) begin
            wd.expired <= 1'b0;
            if (wd.restart) begin
                // Restart first: enable bit still shows its old value here
                state     <= RBW_WDG_RUN;
                msCnt     <= '0;
                elapsedMs <= '0;
                periodMs  <= wdgPeriodMs(wd.timeoutSel);
            end else if (!wd.enable) begin
                state <= RBW_WDG_IDLE;
            end else begin
                case (state)
                    RBW_WDG_RUN: begin
                        msCnt <= msTick ? '0 : msCnt + 1'b1;
                        if (msTick) begin
                            if (elapsedMs == periodMs - 1'b1) begin
                                wd.expired <= 1'b1;
                                elapsedMs  <= '0;
                            end else begin
                                elapsedMs <= elapsedMs + 1'b1;
                            end
                        end
                    end
                    RBW_WDG_IDLE: begin
                        msCnt     <= '0;
                        elapsedMs <= '0;
                    end
                    default: state <= RBW_WDG_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    no_supervise_a: assert property (ce && !wd.enable |=> !wd.expired)
        else $error("watchdog fired while disabled");
    period_load_a: assert property (ce && wd.restart
        |=> periodMs == wdgPeriodMs($past(wd.timeoutSel)) && elapsedMs == '0)
        else $error("period not loaded on restart");
    expiry_count_a: assert property ($rose(wd.expired)
        |-> $past(elapsedMs) == periodMs - 1'b1 && $past(msTick))
        else $error("watchdog fired before its period");
    expire_c: cover property (wd.expired);
endmodule
`default_nettype wire

/* File: rtl/rbw_register_bank.sv */
// Watchdog and analog control register bank behind an AXI4-Lite slave.
// Assumes one core clock, a synchronous reset and pin status inputs.
//
// Summary of operation
// - Decode indices 0,1,2,3,5,8,9 to seven registers
// - Watchdog register: enable bit 7, timeout 3:0
// - Timeout code maps 33 ms to 524 ms
// - Enable rewrite restarts period, else event
// - Enable clear stops supervision, set starts
// - Watchdog bits 6:4 read zero, ignore writes
// - Regulator and converter enables, set at reset
// - Clock output enabled, trigger disabled at reset
// - Current limit code bits 2:0, reset 100
// - Trigger pin shows activity or floats
// - Analog control zero bit 7 reads zero
//
// Implementation choice: the AXI4-Lite slave port.
`include "rbw_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module rbw_register_bank
    import rbw_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `RBW_MS_CYCLES,
    parameter rbw_byte_t   REVISION  = `RBW_REV_DEFAULT // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic [6:0]  analogStatusPins,
    input  wire logic        txActivity,
    output logic             hvRegulatorEnable,
    output logic             secondConverterEnable,
    output logic             clockOutputEnable,
    output logic [2:0]       hvRegulatorCurrentLimit,
    output rbw_byte_t        analogControlOne,
    output logic             triggerOut,
    output logic             triggerOe_n,
    output logic             watchdogEvent,
    output logic             irq
);
    rbw_wdg_if wdg ();

    localparam rbw_byte_t ACZ_RESET = `RBW_ACZ_RST;

    rbw_byte_t   watchdogControl;
    rbw_byte_t   analogControlZero;
    logic [6:0]  statusMeta;
    logic [6:0]  statusSync;
    logic        irqStatus;
    logic        irqMask;
    logic        awHeld;
    logic        wHeld;
    logic [5:0]  wrIndex;
    logic [7:0]  wrData;
    logic        wrLane0;
    logic        doWrite;
    logic        wrHit;
    logic        rdHit;
    logic [31:0] rdWord;
    logic [5:0]  rdIndex;

    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign rdIndex = s_axi_araddr[7:2];

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Write address and data channels, taken in either order
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awHeld        <= 1'b0;
            wrIndex       <= '0;
            s_axi_awready <= 1'b0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld        <= 1'b1;
                wrIndex       <= s_axi_awaddr[7:2];
                s_axi_awready <= 1'b0;
            end else begin
                if (doWrite) begin
                    awHeld <= 1'b0;
                end
                s_axi_awready <= !awHeld && (!s_axi_bvalid || s_axi_bready);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wHeld        <= 1'b0;
            wrData       <= '0;
            wrLane0      <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld        <= 1'b1;
                wrData       <= s_axi_wdata[7:0];
                wrLane0      <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else begin
                if (doWrite) begin
                    wHeld <= 1'b0;
                end
                s_axi_wready <= !wHeld && (!s_axi_bvalid || s_axi_bready);
            end
        end
    end

    always_comb begin
        case (wrIndex)
            `RBW_IDX_WDG, `RBW_IDX_ACZ, `RBW_IDX_ACO, `RBW_IDX_STAT,
            `RBW_IDX_REV, `RBW_IDX_IRQS, `RBW_IDX_IRQM: wrHit = 1'b1;
            default: wrHit = 1'b0;
        endcase
    end

    // Write response; unmapped words answer with a slave error
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RBW_RESP_OKAY;
        end else if (ce) begin
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? `RBW_RESP_OKAY : `RBW_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Control registers; reserved bits are never stored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            watchdogControl <= `RBW_WDG_RST;
        end else if (ce && doWrite && wrLane0 && wrIndex == `RBW_IDX_WDG) begin
            watchdogControl <= wrData & `RBW_WDG_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            analogControlZero <= `RBW_ACZ_RST;
        end else if (ce && doWrite && wrLane0 && wrIndex == `RBW_IDX_ACZ) begin
            analogControlZero <= wrData & `RBW_ACZ_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            analogControlOne <= `RBW_ACO_RST;
        end else if (ce && doWrite && wrLane0 && wrIndex == `RBW_IDX_ACO) begin
            analogControlOne <= wrData & `RBW_ACO_MASK;
        end
    end

    // Enable bits sit in flops of their own so outputs stay registered
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hvRegulatorEnable       <= ACZ_RESET[`RBW_HV_EN_BIT];
            secondConverterEnable   <= ACZ_RESET[`RBW_CONV_EN_BIT];
            clockOutputEnable       <= ACZ_RESET[`RBW_CLK_EN_BIT];
            hvRegulatorCurrentLimit <= ACZ_RESET[`RBW_CLIM_MSB:0];
        end else if (ce && doWrite && wrLane0 && wrIndex == `RBW_IDX_ACZ) begin
            hvRegulatorEnable       <= wrData[`RBW_HV_EN_BIT];
            secondConverterEnable   <= wrData[`RBW_CONV_EN_BIT];
            clockOutputEnable       <= wrData[`RBW_CLK_EN_BIT];
            hvRegulatorCurrentLimit <= wrData[`RBW_CLIM_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Trigger pin, active low enable floats the pin when disabled
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            triggerOut  <= 1'b0;
            triggerOe_n <= 1'b1;
        end else if (ce) begin
            triggerOut  <= txActivity;
            triggerOe_n <= !analogControlZero[`RBW_TRIG_EN_BIT];
        end
    end

    // Status pins come from the analog domain, two flops first
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            statusMeta <= '0;
            statusSync <= '0;
        end else if (ce) begin
            statusMeta <= analogStatusPins;
            statusSync <= statusMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Watchdog hookup; only a write with the enable bit set restarts
    assign wdg.enable     = watchdogControl[`RBW_WDG_EN_BIT];
    // The restarting write carries the code; the register updates a cycle late
    assign wdg.timeoutSel = wdg.restart ? wrData[`RBW_WDG_SEL_MSB:0]
                                        : watchdogControl[`RBW_WDG_SEL_MSB:0];
    assign wdg.restart    = doWrite && wrLane0 && wrIndex == `RBW_IDX_WDG
                            && wrData[`RBW_WDG_EN_BIT];

    rbw_watchdog #(
        .MS_CYCLES (MS_CYCLES)
    ) u_watchdog (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .wd      (wdg.timer)
    );

    // Sticky event flag; a new event outranks a clearing write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqStatus <= 1'b0;
            irqMask   <= 1'b0;
        end else if (ce) begin
            if (wdg.expired) begin
                irqStatus <= 1'b1;
            end else if (doWrite && wrLane0 && wrIndex == `RBW_IDX_IRQS
                         && wrData[`RBW_IRQ_WDG_BIT]) begin
                irqStatus <= 1'b0;
            end
            if (doWrite && wrLane0 && wrIndex == `RBW_IDX_IRQM) begin
                irqMask <= wrData[`RBW_IRQ_WDG_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            watchdogEvent <= 1'b0;
            irq           <= 1'b0;
        end else if (ce) begin
            watchdogEvent <= wdg.expired;
            irq           <= irqStatus && irqMask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Read channel, one word at a time
    always_comb begin
        rdHit  = 1'b1;
        rdWord = '0;
        case (rdIndex)
            `RBW_IDX_WDG:  rdWord[7:0] = watchdogControl;
            `RBW_IDX_ACZ:  rdWord[7:0] = analogControlZero;
            `RBW_IDX_ACO:  rdWord[7:0] = analogControlOne;
            `RBW_IDX_STAT: rdWord[6:0] = statusSync;
            `RBW_IDX_REV:  rdWord[7:0] = REVISION;
            `RBW_IDX_IRQS: rdWord[`RBW_IRQ_WDG_BIT] = irqStatus;
            `RBW_IDX_IRQM: rdWord[`RBW_IRQ_WDG_BIT] = irqMask;
            default:       rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `RBW_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rdWord;
                s_axi_rresp   <= rdHit ? `RBW_RESP_OKAY : `RBW_RESP_SLVERR;
            end else begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
                s_axi_arready <= !s_axi_rvalid || s_axi_rready;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    wdg_reserved_a: assert property (watchdogControl[6:4] == 3'h0)
        else $error("watchdog reserved bits set");
    acz_reserved_a: assert property (analogControlZero[7] == 1'b0)
        else $error("analog control bit 7 set");
    reset_values_a: assert property ($fell(sys_rst) |-> hvRegulatorEnable
        && secondConverterEnable && clockOutputEnable && triggerOe_n
        && hvRegulatorCurrentLimit == ACZ_RESET[`RBW_CLIM_MSB:0])
        else $error("control outputs wrong after reset");
    trig_drive_a: assert property (ce && analogControlZero[`RBW_TRIG_EN_BIT]
        |=> !triggerOe_n && triggerOut == $past(txActivity))
        else $error("trigger pin not following activity");
    trig_float_a: assert property (ce && !analogControlZero[`RBW_TRIG_EN_BIT]
        |=> triggerOe_n)
        else $error("trigger pin driven while disabled");
    unmapped_read_a: assert property (ce && s_axi_arvalid && s_axi_arready
        && rdIndex == 6'h04 |=> s_axi_rvalid && s_axi_rresp == `RBW_RESP_SLVERR)
        else $error("gap address not refused");
    event_sticky_a: assert property (ce && wdg.expired
        |=> irqStatus ##0 watchdogEvent)
        else $error("watchdog event lost");
    write_resp_a: assert property (ce && doWrite
        |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write not answered");
    limit_write_a: assert property (ce && doWrite && wrLane0 && wrIndex == `RBW_IDX_ACZ
        |=> hvRegulatorCurrentLimit == $past(wrData[`RBW_CLIM_MSB:0]))
        else $error("current limit not updated");

    write_c: cover property (s_axi_bvalid && s_axi_bready);
    read_c: cover property (s_axi_rvalid && s_axi_rready);
    irq_c: cover property (irq);
    trig_c: cover property (!triggerOe_n);
endmodule
`default_nettype wire

/* File: testbench/rbw_host_model.sv */
// Host bus master model for the register bank's AXI4-Lite slave.
// Assumes the slave shares clk; every wait is bounded.
`timescale 1ns/100ps
`default_nettype none
module rbw_host_model (
    input  wire logic        clk,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    input  wire logic [1:0]  s_axi_bresp,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    output logic [7:0]       s_axi_araddr,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    end
    ////////////////////////////////////////////////////////////
    // Released payload is inverted, so stale values never pass
    task automatic write(input logic [5:0] i, input logic [7:0] d, input int s,
                         output logic [1:0] r, output bit ok);
        bit a;
        bit w;
        int n;
        a = 0;
        w = 0;
        n = 0;
        @(posedge clk);
        s_axi_awaddr  <= {i, 2'h0};
        s_axi_wdata   <= {24'h000000, d};
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!(a && w) && n < 99) begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) begin
                a = 1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~s_axi_wdata;
            end
        end
        repeat (s) @(posedge clk);
        s_axi_bready <= 1'b1;
        @(posedge clk);
        while (!s_axi_bvalid && n < 199) begin
            @(posedge clk);
            n++;
        end
        r = s_axi_bresp;
        ok = s_axi_bvalid;
        s_axi_bready <= 1'b0;
    endtask
    task automatic read(input logic [5:0] i, input int s, output bit ok);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr  <= {i, 2'h0};
        s_axi_arvalid <= 1'b1;
        @(posedge clk);
        while (!s_axi_arready && n < 99) begin
            @(posedge clk);
            n++;
        end
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~s_axi_araddr;
        repeat (s) @(posedge clk);
        s_axi_rready <= 1'b1;
        @(posedge clk);
        while (!s_axi_rvalid && n < 199) begin
            @(posedge clk);
            n++;
        end
        ok = s_axi_rvalid;
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: testbench/test_device_register_bank_watchdog.sv */
// Self-checking bench of the watchdog and analog control register bank.
// Assumes the host model as bus master and a 4-cycle millisecond.
`timescale 1ns/100ps
`default_nettype none
module test_device_register_bank_watchdog;
    import rbw_pkg::*;
    localparam int unsigned MSC = 4;
    localparam rbw_byte_t   REV = 8'h3c; // Arbitrary value
    logic        clk, sys_rst, ce, txActivity, triggerOut, triggerOe_n, watchdogEvent, irq;
    logic        hvRegulatorEnable, secondConverterEnable, clockOutputEnable;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [6:0]  analogStatusPins;
    logic [2:0]  hvRegulatorCurrentLimit;
    rbw_byte_t   analogControlOne;
    logic [33:0] expQ[$];
    int          nMismatch = 0;
    int          nCompared = 0;
    int          msTab[16] = '{33, 66, 98, 131, 164, 197, 229, 262, 295, 328, 360, 393,
                               426, 459, 492, 524};
    rbw_register_bank #(.MS_CYCLES(MSC), .REVISION(REV)) dut (.*);
    rbw_host_model host (.*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic giveVerdict();
        $display("compared %0d, mismatched %0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic checkVal(input logic [31:0] act, input logic [31:0] exp);
        nCompared++;
        if (act !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: %h, wanted %h", $time, act, exp);
        end
    endtask
    task automatic checkRead(input logic [33:0] act, input logic [33:0] exp);
        nCompared++;
        if (act !== exp) begin
            nMismatch++;
            $display("unexpected read at %0t: %h, wanted %h", $time, act, exp);
        end
    endtask
    // Read answers are matched in order against the queued notes
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            checkRead({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
        end
    end
    task automatic hang();
        nMismatch++;
        giveVerdict();
    endtask
    task automatic wr(input logic [5:0] i, input rbw_byte_t d, input logic [1:0] e);
        logic [1:0] r;
        bit         ok;
        host.write(i, d, $urandom_range(2), r, ok);
        if (!ok) hang();
        checkVal(32'(r), 32'(e));
    endtask
    task automatic rd(input logic [5:0] i, input rbw_byte_t d, input logic [1:0] e);
        bit ok;
        expQ.push_back({e, 24'h000000, d});
        host.read(i, $urandom_range(2), ok);
        if (!ok) hang();
    endtask
    // Each enabling write restarts the period with its own code
    task automatic expire(input logic [3:0] c, input logic m);
        int n;
        n = 0;
        wr(6'h00, {4'h8, c}, 2'h0);
        while (watchdogEvent !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) hang();
        checkVal(32'(n > MSC * msTab[c] - 4 && n < MSC * msTab[c] + 4), 32'h1);
        @(posedge clk);
        checkVal({watchdogEvent, irq}, {1'b0, m});
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        rbw_byte_t d;
        logic      t;
        int        n;
        void'($urandom(44613));
        sys_rst = 1'b1;
        ce = 1'b1;
        txActivity = 1'b0;
        analogStatusPins = 7'h00;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        checkVal({hvRegulatorEnable, secondConverterEnable, clockOutputEnable,
                  hvRegulatorCurrentLimit, triggerOe_n, watchdogEvent, irq}, 9'h1e4);
        rd(6'h00, 8'h0f, 2'h0);
        rd(6'h01, 8'h74, 2'h0);
        rd(6'h02, 8'h60, 2'h0);
        rd(6'h05, REV, 2'h0);
        rd(6'h04, 8'h00, 2'h2);
        wr(6'h06, 8'h55, 2'h2);
        wr(6'h05, 8'h00, 2'h0);
        rd(6'h05, REV, 2'h0);
        analogStatusPins <= 7'($urandom);
        repeat (4) @(posedge clk);
        rd(6'h03, {1'b0, analogStatusPins}, 2'h0);
        wr(6'h00, 8'h7a, 2'h0);
        rd(6'h00, 8'h0a, 2'h0);
        wr(6'h02, 8'hff, 2'h0);
        rd(6'h02, 8'h7e, 2'h0);
        checkVal(analogControlOne, 8'h7e);
        repeat (6) begin
            d = 8'($urandom);
            wr(6'h01, d, 2'h0);
            rd(6'h01, d & 8'h7f, 2'h0);
            checkVal({hvRegulatorEnable, secondConverterEnable, clockOutputEnable,
                      hvRegulatorCurrentLimit, triggerOe_n}, {d[6:4], d[2:0], ~d[3]});
        end
        wr(6'h01, 8'h08, 2'h0);
        for (int k = 0; k < 24; k++) begin
            @(posedge clk);
            if (k > 0) checkVal({triggerOut, triggerOe_n}, {t, 1'b0});
            t = txActivity;
            txActivity <= 1'($urandom);
        end
        wr(6'h09, 8'h01, 2'h0);
        rd(6'h09, 8'h01, 2'h0);
        wr(6'h00, 8'h80, 2'h0);
        repeat (100) @(posedge clk);
        for (int c = 0; c < 16; c++) expire(4'(c), 1'b1);
        wr(6'h00, 8'h80, 2'h0);
        wr(6'h00, 8'h00, 2'h0);
        n = 0;
        repeat (600) begin
            @(posedge clk);
            if (watchdogEvent !== 1'b0) n++;
        end
        checkVal(n, 0);
        checkVal(irq, 1'b1);
        rd(6'h08, 8'h01, 2'h0);
        wr(6'h08, 8'h01, 2'h0);
        repeat (2) @(posedge clk);
        checkVal(irq, 1'b0);
        rd(6'h08, 8'h00, 2'h0);
        wr(6'h09, 8'h00, 2'h0);
        expire(4'h0, 1'b0);
        wr(6'h00, 8'h00, 2'h0);
        rd(6'h08, 8'h01, 2'h0);
        checkVal(irq, 1'b0);
        giveVerdict();
    end
endmodule
`default_nettype wire
